// ---- rtl/cpt_carrier_timer.sv ----
// Carrier pulse timer: low/high reload carrier or one-shot pulse on the
// output flip-flop, interval events, companion 8-bit counter, AHB-Lite.
// Assumes a single-slave AHB-Lite segment on clk_sys_in.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps

module cpt_carrier_timer #(
  parameter int DIV = cpt_pkg::CNT_DIV
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [cpt_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [cpt_pkg::DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [cpt_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Carrier output and interrupt.
  output logic carrier_output_pin_out,
  output logic irq_out
);
  import cpt_pkg::*;
  // Longest start delay in system clocks, divider phase included.
  localparam int START_WIN = START_DELAY_TICKS * DIV + 3;

  // ==========================================================================
  // Declarations
  logic [CTRL_W-1:0] carrier_timer_control;
  logic [RLD_W-1:0] low_reload_value, high_reload_value;
  logic [STAT_W-1:0] status, mask, status_set;
  logic [7:0] comp_count;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] next_rdata;
  logic wr_q, acc, rd_stat, wr_ctrl, wr_low, wr_high, wr_mask, wr_comp;
  cpt_state_e state;
  logic [8:0] cnt, ld_val, ph_len, ph_ticks;
  logic pin, pin_q, div_tick, tick, output_level_flag, idle_lvl;
  logic start_req, stop_req, phase_end, load_evt, os_done, comp_rise, comp_ovf;

  // ==========================================================================
  // Decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction : hit

  // Count to load for a phase at level lv; the swap follows the flag.
  function automatic logic [8:0] phase_load(input logic lv,
                                            input logic flag,
                                            input logic [RLD_W-1:0] lo,
                                            input logic [RLD_W-1:0] hi);
    logic [RLD_W-1:0] sel;
    sel = (lv ^ flag) ? hi : lo;
    return {1'b0, sel} + 9'h001;
  endfunction : phase_load

  // ==========================================================================
  // AHB-Lite address and data phases
  // Every transfer completes with no wait state, so only the size of the
  // transfer is left unchecked; sub-word writes store the whole word.
  assign acc = hsel_in & htrans_in[1] & hready_in;
  assign wr_ctrl = wr_q & hit(addr_q, OFF_CTRL);
  assign wr_low = wr_q & hit(addr_q, OFF_LOW);
  assign wr_high = wr_q & hit(addr_q, OFF_HIGH);
  assign wr_mask = wr_q & hit(addr_q, OFF_MASK);
  assign wr_comp = wr_q & hit(addr_q, OFF_COMP);
  assign rd_stat = acc & !hwrite_in & hit(haddr_in, OFF_STAT);

  // Address phase capture for the following data phase.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_q <= 1'b0;
      addr_q <= '0;
    end else if (hready_in) begin
      wr_q <= acc & hwrite_in;
      addr_q <= haddr_in;
    end
  end

  // Read data selection; unmapped addresses read as zero.
  always_comb begin
    next_rdata = '0;
    if (hit(haddr_in, OFF_CTRL)) begin
      next_rdata = DATA_W'(carrier_timer_control);
    end else if (hit(haddr_in, OFF_LOW)) begin
      next_rdata = DATA_W'(low_reload_value);
    end else if (hit(haddr_in, OFF_HIGH)) begin
      next_rdata = DATA_W'(high_reload_value);
    end else if (hit(haddr_in, OFF_STAT)) begin
      next_rdata = DATA_W'(status);
    end else if (hit(haddr_in, OFF_MASK)) begin
      next_rdata = DATA_W'(mask);
    end else if (hit(haddr_in, OFF_COMP)) begin
      next_rdata = DATA_W'(comp_count);
    end
  end

  // Read data, ready and response registers.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      hrdata_out <= '0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (acc && !hwrite_in) begin
        hrdata_out <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // Software registers
  assign output_level_flag = carrier_timer_control[CB_LEVEL];

  // Control; a finished one-shot drops the start bit by itself.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      carrier_timer_control <= CTRL_RST;
    end else if (wr_ctrl) begin
      carrier_timer_control <= hwdata_in[CTRL_W-1:0];
    end else if (os_done) begin
      carrier_timer_control[CB_START] <= 1'b0;
    end
  end

  // Reload values are taken only at phase starts, so a rewrite never
  // cuts a running phase short.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      low_reload_value <= RELOAD_RST;
      high_reload_value <= RELOAD_RST;
    end else begin
      if (wr_low) begin
        low_reload_value <= hwdata_in[RLD_W-1:0];
      end
      if (wr_high) begin
        high_reload_value <= hwdata_in[RLD_W-1:0];
      end
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mask <= MASK_RST;
    end else if (wr_mask) begin
      mask <= hwdata_in[STAT_W-1:0];
    end
  end

  // ==========================================================================
  // Counting clock
  // Raw selection ticks on every clock; otherwise the divider paces it.
  cpt_tick_div #(
    .DIV(DIV)
  ) u_div (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(state != CPT_IDLE),
    .tick_out(div_tick)
  );

  assign tick = carrier_timer_control[CB_CLKSEL] | div_tick;

  // ==========================================================================
  // Timer sequencer
  assign idle_lvl = wr_ctrl ? hwdata_in[CB_LEVEL] : output_level_flag;
  assign start_req = wr_ctrl & hwdata_in[CB_START] & (state == CPT_IDLE);
  assign stop_req = wr_ctrl & !hwdata_in[CB_START];
  assign ld_val = phase_load(!pin, output_level_flag, low_reload_value,
                             high_reload_value);
  assign phase_end = (state == CPT_RUN) & tick & (cnt == 9'h000);
  assign os_done = phase_end & !carrier_timer_control[CB_REPEAT];
  assign load_evt = tick & (cnt == 9'h000) & !stop_req &
    ((state == CPT_DELAY) ||
     ((state == CPT_RUN) && carrier_timer_control[CB_REPEAT]));

  // Each phase loads reload+1 and ends on the tick after zero, so it
  // lasts reload+2 counting clocks.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= CPT_IDLE;
      cnt <= 9'h000;
      pin <= 1'b0;
    end else if (stop_req && state != CPT_IDLE) begin
      state <= CPT_IDLE;
      pin <= hwdata_in[CB_LEVEL];
    end else begin
      unique case (state)
        CPT_IDLE: begin
          pin <= idle_lvl;
          if (start_req) begin
            state <= CPT_DELAY;
            cnt <= 9'(START_DELAY_TICKS - 1);
          end
        end
        CPT_DELAY: begin
          if (tick && cnt == 9'h000) begin
            pin <= !pin;
            cnt <= ld_val;
            state <= CPT_RUN;
          end else if (tick) begin
            cnt <= cnt - 9'h001;
          end
        end
        CPT_RUN: begin
          if (os_done) begin
            pin <= output_level_flag;
            state <= CPT_IDLE;
          end else if (phase_end) begin
            pin <= !pin;
            cnt <= ld_val;
          end else if (tick) begin
            cnt <= cnt - 9'h001;
          end
        end
      endcase
    end
  end

  // Output pin register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      carrier_output_pin_out <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      carrier_output_pin_out <= pin;
      pin_q <= pin;
    end
  end

  // ==========================================================================
  // Companion counter
  // Counts rising edges of the timer output; it keeps its value when the
  // timer stops so software can read a pulse total.
  assign comp_rise = pin & !pin_q;
  assign comp_ovf = carrier_timer_control[CB_COMP] & comp_rise &
    (comp_count == 8'hff);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      comp_count <= COMP_RST;
    end else if (wr_comp) begin
      comp_count <= hwdata_in[7:0];
    end else if (carrier_timer_control[CB_COMP] && comp_rise) begin
      comp_count <= comp_count + 8'h01;
    end
  end

  // ==========================================================================
  // Status and interrupt
  always_comb begin
    status_set = '0;
    status_set[SB_INTERVAL] = phase_end;
    status_set[SB_COMP_OVF] = comp_ovf;
    status_set[SB_ONESHOT] = os_done;
  end

  // A read clears the bits it returned; an event in that cycle survives.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      status <= '0;
    end else begin
      status <= (rd_stat ? '0 : status) | status_set;
    end
  end

  // The waveform keeps running with the enable off; only the request
  // is held back.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= carrier_timer_control[CB_IEN] &
        (|(status & mask));
    end
  end

  // ==========================================================================
  // Checking helpers: length and tick count of the current phase.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ph_len <= 9'h000;
      ph_ticks <= 9'h000;
    end else if (load_evt) begin
      ph_len <= ld_val + 9'h001;
      ph_ticks <= 9'h000;
    end else if (tick && state == CPT_RUN) begin
      ph_ticks <= ph_ticks + 9'h001;
    end
  end

  // ==========================================================================
  // Assertions
  a_phase_length: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    phase_end |-> ph_ticks == ph_len - 9'h001)
    else $error("phase length differs from reload plus two");
  a_low_plain: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    load_evt && pin && !output_level_flag
    |=> ph_len == {1'b0, $past(low_reload_value)} + 9'h002)
    else $error("low phase did not use the low reload");
  a_low_swapped: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    load_evt && pin && output_level_flag
    |=> ph_len == {1'b0, $past(high_reload_value)} + 9'h002)
    else $error("swapped low phase did not use the high reload");
  a_interval_event: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    phase_end |=> status[SB_INTERVAL])
    else $error("elapsed period left no interval status");
  a_comp_overflow: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    comp_ovf && !wr_comp |=> status[SB_COMP_OVF] && comp_count == 8'h00)
    else $error("companion overflow not flagged");
  a_repeat_runs: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    phase_end && carrier_timer_control[CB_REPEAT] && !stop_req
    |=> state == CPT_RUN && pin != $past(pin))
    else $error("repeat mode did not toggle and continue");
  a_oneshot_end: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    os_done && !wr_ctrl |=> state == CPT_IDLE &&
      !carrier_timer_control[CB_START] && pin == $past(output_level_flag))
    else $error("one-shot did not stop at idle level");
  a_preset_high: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wr_ctrl && hwdata_in[CB_LEVEL] && state == CPT_IDLE
    |=> ##1 carrier_output_pin_out)
    else $error("preset did not drive the output high");
  a_start_edge: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $past(state) == CPT_DELAY && state == CPT_RUN |-> pin != $past(pin))
    else $error("start delay ended without an output edge");
  a_start_bound: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    start_req |-> ##[1:START_WIN] state != CPT_DELAY)
    else $error("start delay ran past its tick count");
  a_irq_gate: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !carrier_timer_control[CB_IEN] |=> !irq_out)
    else $error("interrupt raised while disabled");
  a_div_clock: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !carrier_timer_control[CB_CLKSEL] && tick && DIV > 1 |=> !tick)
    else $error("divided counting clock ticked twice in a row");

endmodule : cpt_carrier_timer

// ---- rtl/cpt_pkg.sv ----
// Shared constants for the carrier pulse timer: register map, field
// positions, reset values, state encoding and timing figures.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package cpt_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int RLD_W = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOW = 8'h04;
  localparam logic [7:0] OFF_HIGH = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_COMP = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_W = 6;
  localparam int CB_LEVEL = 0;
  localparam int CB_START = 1;
  localparam int CB_REPEAT = 2;
  localparam int CB_CLKSEL = 3;
  localparam int CB_IEN = 4;
  localparam int CB_COMP = 5;

  // ==========================================================================
  // Status and mask register fields
  localparam int STAT_W = 3;
  localparam int SB_INTERVAL = 0;
  localparam int SB_COMP_OVF = 1;
  localparam int SB_ONESHOT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [RLD_W-1:0] RELOAD_RST = 8'h01;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
  localparam logic [7:0] COMP_RST = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CNT_DIV = 4;
  localparam int START_DELAY_NS = 750;
  localparam int REF_TICK_NS = 250;
  localparam int START_DELAY_TICKS =
    (START_DELAY_NS + REF_TICK_NS - 1) / REF_TICK_NS;

  // ==========================================================================
  // Timer sequencer states
  typedef enum logic [1:0] {CPT_IDLE, CPT_DELAY, CPT_RUN} cpt_state_e;

endpackage : cpt_pkg

// ---- rtl/cpt_tick_div.sv ----
// Counting-clock divider: one-cycle enable pulse every DIV system clocks.
// Assumes run_in comes from logic on the same clock.
`timescale 1ns/10ps
module cpt_tick_div #(
  parameter int DIV = cpt_pkg::CNT_DIV
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control and enable pulse.
  input wire logic run_in,
  output logic tick_out
);
  import cpt_pkg::*;

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt;

  // ==========================================================================
  // Divider
  // Held at zero while stopped so each run starts with the same phase.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : cpt_tick_div

// ---- tb/cpt_ir_stage.sv ----
// Far-side model: an output stage that times each level of the carrier pin.
// Assumes the pin is a registered output on the same system clock.
`timescale 1ns/10ps
module cpt_ir_stage (
  // Clock.
  input wire logic clk_sys_in,
  // Carrier pin from the timer.
  input wire logic carrier_in,
  // Last phase lengths in clocks, and edge counts.
  output logic [15:0] low_len_out,
  output logic [15:0] high_len_out,
  output logic [15:0] n_rise_out,
  output logic [15:0] n_fall_out
);
  logic prev = 1'b0;
  logic [15:0] cnt = 16'h0001;

  initial begin
    low_len_out = 16'h0000;
    high_len_out = 16'h0000;
    n_rise_out = 16'h0000;
    n_fall_out = 16'h0000;
  end

  // =========================================================================
  // Phase timer
  // A level is timed from the edge that began it to the edge that ends it,
  // so a length is only valid once the following edge has been seen.
  always @(posedge clk_sys_in) begin
    if ((carrier_in === 1'b1) != prev) begin
      if (prev) begin
        high_len_out <= cnt;
      end else begin
        low_len_out <= cnt;
      end
      if (carrier_in) begin
        n_rise_out <= n_rise_out + 16'h0001;
      end else begin
        n_fall_out <= n_fall_out + 16'h0001;
      end
      cnt <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
    end
    // An unknown level before reset counts as low, so no false edge.
    prev <= (carrier_in === 1'b1);
  end
endmodule : cpt_ir_stage

// ---- tb/carrier_pulse_timer_tb.sv ----
// Self-checking bench for the carrier pulse timer over AHB-Lite.
// Assumes the design package and the output stage model are compiled first.
`timescale 1ns/10ps
module carrier_pulse_timer_tb;
  import cpt_pkg::*;
  // A short divider keeps the divided-clock case quick.
  localparam int DIV_TB = 2;
  logic clk_sys = 1'b0;
  logic rst, hsel, hwrite, hreadyout, hresp, pin, irq, irq_seen;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] low_len, high_len, n_rise, n_fall;
  int n_errors = 0;
  int checks = 0;

  // =========================================================================
  // Clock, design and output stage
  always #2.5 clk_sys = ~clk_sys;

  cpt_carrier_timer #(.DIV(DIV_TB)) i_dut (.clk_sys_in(clk_sys),
    .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp),
    .carrier_output_pin_out(pin), .irq_out(irq));

  cpt_ir_stage i_stage (.clk_sys_in(clk_sys), .carrier_in(pin),
    .low_len_out(low_len), .high_len_out(high_len),
    .n_rise_out(n_rise), .n_fall_out(n_fall));

  // =========================================================================
  // Reporting
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // =========================================================================
  // Bus master: hold each phase until hready is seen high at an edge.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) begin
        chk(32'h0, 32'h1, "bus hang");
        summarize();
      end
      @(posedge clk_sys);
    end
  endtask : wait_rdy

  task automatic bus_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask : bus_xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    bus_xfer(1'b0, a, 32'h0);
  endtask : bus_rd

  // Waits for n rising edges of the pin, noting any interrupt meanwhile.
  task automatic wait_rise(input int n);
    int k;
    logic [15:0] base;
    k = 0;
    base = n_rise;
    while (16'(n_rise - base) < n) begin
      @(posedge clk_sys);
      irq_seen = irq_seen | (irq === 1'b1);
      k++;
      if (k > 2000) begin
        chk(32'h0, 32'h1, "no carrier edge");
        summarize();
      end
    end
  endtask : wait_rise

  // =========================================================================
  // Scenarios
  task automatic t_reset_values();
    logic [7:0] offs [7];
    logic [31:0] exp [7];
    offs = '{OFF_CTRL, OFF_LOW, OFF_HIGH, OFF_STAT, OFF_MASK, OFF_COMP,
             8'h20};
    exp = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    bus_wr(8'h20, 32'h0000_00ff);
    for (int i = 0; i < 7; i++) begin
      bus_rd(offs[i]);
      chk(rd, exp[i], "reset value");
    end
    chk({30'h0, pin, irq}, 32'h0, "idle outputs");
  endtask : t_reset_values

  task automatic run_carrier(input logic [7:0] ctrl, input int el,
                             input int eh);
    bus_wr(OFF_LOW, 32'h5);
    bus_wr(OFF_HIGH, 32'h3);
    bus_wr(OFF_CTRL, {24'h0, ctrl});
    wait_rise(3);
    chk({16'h0, low_len}, el, "low phase length");
    chk({16'h0, high_len}, eh, "high phase length");
    bus_wr(OFF_CTRL, {31'h0, ctrl[0]});
    repeat (3) @(posedge clk_sys);
    chk({31'h0, pin}, {31'h0, ctrl[0]}, "stop level");
  endtask : run_carrier

  task automatic t_carrier();
    run_carrier(8'h0e, 7, 5);
    run_carrier(8'h0f, 5, 7);
    run_carrier(8'h06, 7 * DIV_TB, 5 * DIV_TB);
  endtask : t_carrier

  task automatic t_oneshot();
    int k;
    logic [15:0] f;
    bus_wr(OFF_LOW, 32'h1);
    bus_wr(OFF_HIGH, 32'h6);
    bus_rd(OFF_STAT);
    bus_wr(OFF_CTRL, 32'h09);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, pin}, 32'h1, "preset high");
    f = n_fall;
    bus_wr(OFF_CTRL, 32'h0b);
    k = 0;
    while (pin !== 1'b0 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    // Raw ticks, then two clocks of pin and output registers.
    chk(32'(k), 32'(START_DELAY_TICKS + 2), "start delay");
    wait_rise(1);
    chk({16'h0, low_len}, 32'd8, "pulse width");
    repeat (30) @(posedge clk_sys);
    chk({16'h0, 16'(n_fall - f)}, 32'h1, "single pulse");
    chk({31'h0, pin}, 32'h1, "idle after pulse");
    bus_rd(OFF_CTRL);
    chk(rd, 32'h09, "start cleared");
    bus_rd(OFF_STAT);
    chk(rd & 32'h5, 32'h5, "pulse done status");
    bus_rd(OFF_STAT);
    chk(rd, 32'h0, "status read clear");
  endtask : t_oneshot

  task automatic t_irq();
    int k;
    bus_wr(OFF_MASK, 32'h1);
    irq_seen = 1'b0;
    bus_wr(OFF_CTRL, 32'h0e);
    wait_rise(2);
    chk({31'h0, irq_seen}, 32'h0, "irq while disabled");
    bus_wr(OFF_CTRL, 32'h1e);
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    chk({31'h0, irq}, 32'h1, "interval irq");
    bus_wr(OFF_CTRL, 32'h10);
    bus_rd(OFF_STAT);
    chk(rd & 32'h1, 32'h1, "interval status");
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    bus_wr(OFF_MASK, 32'h0);
    irq_seen = 1'b0;
    bus_wr(OFF_CTRL, 32'h1e);
    wait_rise(2);
    chk({31'h0, irq_seen}, 32'h0, "irq while masked");
    bus_wr(OFF_CTRL, 32'h00);
    bus_rd(OFF_STAT);
  endtask : t_irq

  task automatic t_companion();
    bus_wr(OFF_COMP, 32'hfe);
    bus_rd(OFF_STAT);
    bus_wr(OFF_CTRL, 32'h2e);
    wait_rise(3);
    bus_wr(OFF_CTRL, 32'h00);
    bus_rd(OFF_COMP);
    chk(rd, 32'h01, "companion count");
    bus_rd(OFF_STAT);
    chk(rd & 32'h2, 32'h2, "companion overflow");
  endtask : t_companion

  // Reset in mid-run: outputs to reset levels, carrier stays stopped.
  task automatic t_reset_mid();
    logic [15:0] r;
    bus_wr(OFF_CTRL, 32'h0e);
    wait_rise(2);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({29'h0, pin, irq, hreadyout}, 32'h1, "outputs in reset");
    rst <= 1'b0;
    r = n_rise;
    bus_rd(OFF_CTRL);
    chk(rd, 32'h0, "control after reset");
    repeat (40) @(posedge clk_sys);
    chk({16'h0, 16'(n_rise - r)}, 32'h0, "carrier after reset");
    bus_rd(OFF_LOW);
    chk(rd, {24'h0, RELOAD_RST}, "reload after reset");
  endtask : t_reset_mid

  // =========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_seen = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_values();
    t_carrier();
    t_oneshot();
    t_irq();
    t_companion();
    t_reset_mid();
    summarize();
  end
endmodule : carrier_pulse_timer_tb
